// ---- rtl/ics_pkg.sv ----
// package: constants, modes and carriers for the interval conversion sequencer
package ics_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int CNT_W = 16;
   localparam int DLY_W = 12;
   // times in ns, as specified
   localparam int DEAD_NS = 5000;
   localparam int GATE_NS = 2000;
   localparam int STOP_DLY_MIN_NS = 1000;
   localparam int STOP_DLY_MAX_NS = 10000;
   localparam int TMO_SHORT_NS = 5000;
   localparam int TMO_LONG_NS = 120000;
   localparam int WSTB_NS = 100;
   // derived counts; least times round up, never below one cycle
   localparam int NS_PER_CLK = 1_000_000_000 / CLK_HZ;
   localparam int DEAD_CYC = (DEAD_NS + NS_PER_CLK - 1) / NS_PER_CLK;
   localparam int GATE_CYC = (GATE_NS + NS_PER_CLK - 1) / NS_PER_CLK;
   localparam int STOP_DLY_MIN_CYC = (STOP_DLY_MIN_NS + NS_PER_CLK - 1) / NS_PER_CLK;
   localparam int STOP_DLY_MAX_CYC = STOP_DLY_MAX_NS / NS_PER_CLK;
   localparam int TMO_SHORT_CYC = TMO_SHORT_NS / NS_PER_CLK;
   localparam int TMO_LONG_CYC = TMO_LONG_NS / NS_PER_CLK;
   localparam int WSTB_CYC = (WSTB_NS + NS_PER_CLK - 1) / NS_PER_CLK;
   // reset values
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [DLY_W-1:0] DLY_RST = 12'h000;

   typedef enum logic [1:0] {
      ICS_STB_STOP,
      ICS_STB_START,
      ICS_STB_EXT
   } ics_stb_src_t;

   // configuration bits carried together
   typedef struct packed {
      ics_stb_src_t stb_src;
      logic [DLY_W-1:0] stop_dly_cyc;
      logic [DLY_W-1:0] start_dly_cyc;
      logic [DLY_W-1:0] gate_cyc;
      logic tmo_long;
      logic [CNT_W-1:0] full_scale;
      logic window_mode;
      logic accept_gating;
      logic coinc_mode;
      logic [CNT_W-1:0] lower_level_threshold;
      logic [CNT_W-1:0] upper_level_threshold;
   } ics_cfg_t;

   typedef struct packed {
      logic true_start;
      logic true_stop;
      logic busy;
   } ics_status_t;
endpackage

// ---- rtl/ics_sequencer.sv ----
// interval conversion sequencer: start/stop timing, strobed readout, window check
`timescale 1ns/1ps
// What this block does
// - accepted start stays latched until the internal reset clears it
// - while latched, drive true start and count the interval
// - no stop before full scale flags overrange, resets without output
// - accepted stop freezes the count and holds it until readout or reset
// - stops are ignored unless a start is latched
// - accepted stop strobes the window checker and, in stop mode, the delay
// - stop mode delays the gate by a set time of 1 to 10 us
// - gate open for gate_cyc cycles (about 2 us when gate_cyc is zero) presents the value; reset when gate closes
// - after any internal reset, starts are refused for about 5 us
// - clearing the start latch also clears the stop latch
// - readout strobe comes from stop delay, start delay or external input
// - every strobe source fires one common gate generator
// - start mode: true start runs a configurable delay, then fires gate
// - external mode: positive strobe pulse fires the gate directly
// - outputs show true start, true stop and busy
// - no strobe after conversion resets after 5 or 120 us, no output
// - window check compares half the held value with both thresholds
// - window compare only on a fixed-width strobe started by the stop
// - above lower and not above upper asserts window accept
// - below lower or above upper gives no window accept
// - window mode upper limit is lower plus upper setting
// - with accept gating on, output only if window checker accepted
// - inhibit aborts measurement and blocks starts while asserted
// - anticoincidence refuses starts on gate; coincidence needs gate
// - external strobe before the stop is ignored
module ics_sequencer (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // pulse and level inputs
   input wire logic start_in,
   input wire logic stop_in,
   input wire logic ext_strobe_in,
   input wire logic gate_in,
   input wire logic inhibit_in,
   input wire logic sync_reset,
   // configuration
   input wire ics_pkg::ics_cfg_t cfg,
   // results
   output ics_pkg::ics_status_t status,
   output logic overrange,
   output logic gate_open,
   output logic [ics_pkg::CNT_W-1:0] out_value,
   output logic window_accept
);
   localparam int CW = ics_pkg::CNT_W;
   localparam int DW = ics_pkg::DLY_W;

   logic start_d_r, stop_d_r, ext_d_r;
   logic start_pe, stop_pe, ext_pe;
   logic start_lat_r, stop_lat_r, conv_done_r;
   logic [CW-1:0] cnt_r;
   logic [DW-1:0] sdly_r, tdly_r, gcnt_r;
   logic sdly_run_r, tdly_run_r, gate_r;
   logic [16:0] tmo_r;
   logic [15:0] dead_r;
   logic wstb_r;
   logic [7:0] wcnt_r;
   logic acc_r, win_r;
   logic ovr_hit, gate_end, tmo_hit, int_reset, gate_fire, start_ok;
   logic [DW-1:0] stop_dly_eff;
   logic [CW:0] half_val, upper_eff;
   logic [16:0] tmo_lim;

   // edge detection on clock-synchronous inputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         start_d_r <= 1'b0;
         stop_d_r <= 1'b0;
         ext_d_r <= 1'b0;
      end else begin
         start_d_r <= start_in;
         stop_d_r <= stop_in;
         ext_d_r <= ext_strobe_in;
      end
   end
   assign start_pe = start_in & ~start_d_r;
   assign stop_pe = stop_in & ~stop_d_r;
   assign ext_pe = ext_strobe_in & ~ext_d_r;

   // start gating: dead time, inhibit, coincidence choice
   assign start_ok = start_pe && !start_lat_r && dead_r == 16'h0000 && !inhibit_in
      && (cfg.coinc_mode ? gate_in : !gate_in);
   assign ovr_hit = start_lat_r && !stop_lat_r && cnt_r >= cfg.full_scale;
   assign gate_end = gate_r && gcnt_r == DW'(1);
   assign tmo_lim = cfg.tmo_long ? 17'(ics_pkg::TMO_LONG_CYC) : 17'(ics_pkg::TMO_SHORT_CYC);
   assign tmo_hit = conv_done_r && !gate_r && tmo_r >= tmo_lim;
   assign int_reset = ovr_hit || gate_end || tmo_hit || inhibit_in || sync_reset;

   // start latch holds until internal reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         start_lat_r <= 1'b0;
      end else if (int_reset) begin
         start_lat_r <= 1'b0;
      end else if (start_ok) begin
         start_lat_r <= 1'b1;
      end
   end

   // stop latch; one stop per conversion, cleared with the start latch
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stop_lat_r <= 1'b0;
      end else if (int_reset || !start_lat_r) begin
         stop_lat_r <= 1'b0;
      end else if (stop_pe && !ovr_hit) begin
         stop_lat_r <= 1'b1;
      end
   end
   // a conversion is complete once the stop is taken
   assign conv_done_r = stop_lat_r;

   // interval count, frozen at stop
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= ics_pkg::CNT_RST;
      end else if (int_reset || (start_ok && !start_lat_r)) begin
         cnt_r <= ics_pkg::CNT_RST;
      end else if (start_lat_r && !stop_lat_r && !(stop_pe)) begin
         cnt_r <= cnt_r + CW'(1);
      end
   end // held once stop_lat_r is set

   // dead time after any internal reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dead_r <= 16'h0000;
      end else if (int_reset) begin
         dead_r <= 16'(ics_pkg::DEAD_CYC);
      end else if (dead_r != 16'h0000) begin
         dead_r <= dead_r - 16'h0001;
      end
   end

   // stop delay clamped to 1..10 us
   always_comb begin
      stop_dly_eff = cfg.stop_dly_cyc;
      if (cfg.stop_dly_cyc < DW'(ics_pkg::STOP_DLY_MIN_CYC)) begin
         stop_dly_eff = DW'(ics_pkg::STOP_DLY_MIN_CYC);
      end else if (cfg.stop_dly_cyc > DW'(ics_pkg::STOP_DLY_MAX_CYC)) begin
         stop_dly_eff = DW'(ics_pkg::STOP_DLY_MAX_CYC);
      end
   end

   // stop-referenced delay timer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sdly_r <= ics_pkg::DLY_RST;
         sdly_run_r <= 1'b0;
      end else if (int_reset) begin
         sdly_run_r <= 1'b0;
      end else if (start_lat_r && !stop_lat_r && stop_pe && !ovr_hit
                   && cfg.stb_src == ics_pkg::ICS_STB_STOP) begin
         sdly_r <= stop_dly_eff;
         sdly_run_r <= 1'b1;
      end else if (sdly_run_r) begin
         sdly_r <= sdly_r - DW'(1);
         if (sdly_r == DW'(1)) begin
            sdly_run_r <= 1'b0;
         end
      end
   end

   // start-referenced delay timer
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tdly_r <= ics_pkg::DLY_RST;
         tdly_run_r <= 1'b0;
      end else if (int_reset) begin
         tdly_run_r <= 1'b0;
      end else if (start_ok && cfg.stb_src == ics_pkg::ICS_STB_START) begin
         tdly_r <= (cfg.start_dly_cyc == '0) ? DW'(1) : cfg.start_dly_cyc;
         tdly_run_r <= 1'b1;
      end else if (tdly_run_r) begin
         tdly_r <= tdly_r - DW'(1);
         if (tdly_r == DW'(1)) begin
            tdly_run_r <= 1'b0;
         end
      end
   end

   // one gate generator for all three sources; only after a stop
   always_comb begin
      case (cfg.stb_src)
         ics_pkg::ICS_STB_STOP: gate_fire = sdly_run_r && sdly_r == DW'(1);
         ics_pkg::ICS_STB_START: gate_fire = tdly_run_r && tdly_r == DW'(1);
         ics_pkg::ICS_STB_EXT: gate_fire = ext_pe;
         default: gate_fire = 1'b0;
      endcase
      // no conversion yet means no readout, including early external strobes
      gate_fire = gate_fire && stop_lat_r && !gate_r && !int_reset
         && (!cfg.accept_gating || acc_r);
   end

   // readout gate
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gate_r <= 1'b0;
         gcnt_r <= ics_pkg::DLY_RST;
      end else if (gate_end || int_reset) begin
         gate_r <= 1'b0;
      end else if (gate_fire) begin
         gate_r <= 1'b1;
         gcnt_r <= (cfg.gate_cyc == '0) ? DW'(ics_pkg::GATE_CYC) : cfg.gate_cyc;
      end else if (gate_r) begin
         gcnt_r <= gcnt_r - DW'(1);
      end
   end

   // strobe timeout counter after conversion
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tmo_r <= 17'h00000;
      end else if (!conv_done_r || int_reset) begin
         tmo_r <= 17'h00000;
      end else if (!gate_r) begin
         tmo_r <= tmo_r + 17'h00001;
      end
   end

   // window checker strobe of fixed width from the stop
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wstb_r <= 1'b0;
         wcnt_r <= 8'h00;
      end else if (int_reset) begin
         wstb_r <= 1'b0;
      end else if (start_lat_r && !stop_lat_r && stop_pe && !ovr_hit) begin
         wstb_r <= 1'b1;
         wcnt_r <= 8'(ics_pkg::WSTB_CYC);
      end else if (wstb_r) begin
         wcnt_r <= wcnt_r - 8'h01;
         if (wcnt_r == 8'h01) begin
            wstb_r <= 1'b0;
         end
      end
   end

   assign half_val = {2'b00, cnt_r[CW-1:1]};
   assign upper_eff = cfg.window_mode
      ? {1'b0, cfg.lower_level_threshold} + {1'b0, cfg.upper_level_threshold}
      : {1'b0, cfg.upper_level_threshold};

   // window result, evaluated only while strobed
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= 1'b0;
         win_r <= 1'b0;
      end else if (int_reset) begin
         acc_r <= 1'b0;
         win_r <= 1'b0;
      end else if (wstb_r) begin
         acc_r <= half_val > {1'b0, cfg.lower_level_threshold} && half_val <= upper_eff;
         win_r <= half_val > {1'b0, cfg.lower_level_threshold} && half_val <= upper_eff;
      end else begin
         win_r <= 1'b0;
      end
   end

   // registered outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status <= '0;
         overrange <= 1'b0;
         gate_open <= 1'b0;
         out_value <= ics_pkg::CNT_RST;
         window_accept <= 1'b0;
      end else begin
         status.true_start <= start_lat_r && !int_reset;
         status.true_stop <= stop_lat_r && !int_reset;
         status.busy <= (start_lat_r && !int_reset) || dead_r != 16'h0000;
         overrange <= ovr_hit;
         // the closing cycle still counts toward the width; other resets cut the gate
         gate_open <= gate_r && (gate_end || !int_reset);
         out_value <= (gate_r && (gate_end || !int_reset)) ? cnt_r : ics_pkg::CNT_RST;
         window_accept <= win_r;
      end
   end

   a_latch_holds: assert property (@(posedge mclk) disable iff (!rst_n)
      start_lat_r && !int_reset |=> start_lat_r) else $error("start latch dropped");
   a_stop_clears: assert property (@(posedge mclk) disable iff (!rst_n)
      !start_lat_r |=> !stop_lat_r) else $error("stop survived reset");
   a_count_held: assert property (@(posedge mclk) disable iff (!rst_n)
      stop_lat_r && $past(stop_lat_r) && !int_reset |=> $stable(cnt_r)) else $error("held drifted");
   a_dead_block: assert property (@(posedge mclk) disable iff (!rst_n)
      int_reset |=> !start_lat_r [*5]) else $error("start within dead time");
   a_stop_needs: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(stop_lat_r) |-> $past(start_lat_r)) else $error("stop without start");
   sequence s_gate_run;
      gate_r && !int_reset ##1 gate_open;
   endsequence
   a_gate_output: assert property (@(posedge mclk) disable iff (!rst_n)
      s_gate_run |-> out_value == cnt_r) else $error("gate output differs from held");
   a_gate_resets: assert property (@(posedge mclk) disable iff (!rst_n)
      gate_end |=> !start_lat_r && !gate_r) else $error("no reset after gate");
   a_ovr_noout: assert property (@(posedge mclk) disable iff (!rst_n)
      ovr_hit |=> !gate_r ##1 !gate_open) else $error("output after overrange");
   a_inhibit_blk: assert property (@(posedge mclk) disable iff (!rst_n)
      inhibit_in |=> !start_lat_r) else $error("start during inhibit");
   a_gate_needs: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(gate_r) |-> $past(stop_lat_r) && (!cfg.accept_gating || $past(acc_r)))
      else $error("gate without stop or accept");
endmodule

// ---- testbench/ics_det_model.sv ----
// detector discriminator and external strobe source model
`timescale 1ns/1ps
module ics_det_model (
   // clock
   input wire logic mclk,
   // bench requests: start, stop, strobe; early lets a strobe precede the stop
   input wire logic [2:0] fire,
   input wire logic early,
   // pulses toward the sequencer
   output logic start_pulse,
   output logic stop_pulse,
   output logic strobe_pulse
);
   logic stop_sent = 1'b0;
   // one-cycle positive pulses, launched a cycle after the request
   always @(negedge mclk) begin
      start_pulse <= fire[0];
      stop_pulse <= fire[1];
      strobe_pulse <= fire[2] & (stop_sent | early);
      if (fire[0]) begin
         stop_sent <= 1'b0;
      end else if (fire[1]) begin
         stop_sent <= 1'b1;
      end
   end
endmodule

// ---- testbench/ics_sequencer_tb.sv ----
// self-checking bench for the interval conversion sequencer
`timescale 1ns/1ps
module ics_sequencer_tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic gate_in = 1'b0;
   logic inhibit_in = 1'b0;
   logic sync_reset = 1'b0;
   logic early = 1'b0;
   logic [2:0] fire = 3'h0;
   logic start_in, stop_in, ext_strobe_in, overrange, gate_open, window_accept;
   logic [15:0] out_value, val, v1, h;
   ics_pkg::ics_cfg_t cfg;
   ics_pkg::ics_status_t status;
   int n_fail = 0;
   int checks = 0;
   int ts, tp, tsl, gw, win, ovr, fg, sc;
   logic tse;
   // window table: lower offset below half, upper offset, mode, gating, accept
   int lo_off[7] = '{1, 0, 5, 1, 2, 0, 1};
   int up_off[7] = '{0, 5, -1, 1, 1, 1, 1};
   logic [6:0] wm = 7'h58;
   logic [6:0] ag = 7'h60;
   logic [6:0] ew = 7'h49;

   always #50 mclk = ~mclk;

   ics_det_model u_src (.mclk(mclk), .fire(fire), .early(early), .start_pulse(start_in),
      .stop_pulse(stop_in), .strobe_pulse(ext_strobe_in));

   ics_sequencer dut (.mclk(mclk), .rst_n(rst_n), .start_in(start_in), .stop_in(stop_in),
      .ext_strobe_in(ext_strobe_in), .gate_in(gate_in), .inhibit_in(inhibit_in),
      .sync_reset(sync_reset), .cfg(cfg), .status(status), .overrange(overrange),
      .gate_open(gate_open), .out_value(out_value), .window_accept(window_accept));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // one fixed-length run: requests at the given cycles (-1 never), outputs watched
   task automatic conv(input int s1, input int s2, input int sp, input int ex, input int ih,
                       input int n);
      ts = 0; tp = 0; tsl = 0; gw = 0; win = 0; ovr = 0; fg = -1; sc = -1;
      for (int c = 0; c < n; c++) begin
         @(negedge mclk);
         fire <= {c == ex, c == sp, c == s1 || c == s2};
         inhibit_in <= ih >= 0 && c >= ih && c < ih + 40;
         #1;
         if (stop_in === 1'b1 && sc < 0) sc = c;
         ts = ts | (status.true_start === 1'b1);
         tp = tp | (status.true_stop === 1'b1);
         tsl = tsl | (ih >= 0 && c >= ih + 5 && c < ih + 40 && status.true_start !== 1'b0);
         win = win | (window_accept === 1'b1);
         ovr = ovr | (overrange === 1'b1);
         tse = status.true_start;
         if (gate_open === 1'b1) begin
            gw++;
            val = out_value;
            if (fg < 0) fg = c;
         end
      end
   endtask

   initial begin
      cfg = '{stb_src: ics_pkg::ICS_STB_STOP, stop_dly_cyc: 12'd10, start_dly_cyc: 12'd100,
         gate_cyc: 12'd20, tmo_long: 1'b0, full_scale: 16'd200, window_mode: 1'b0,
         accept_gating: 1'b0, coinc_mode: 1'b0, lower_level_threshold: 16'h0000,
         upper_level_threshold: 16'hffff};
      repeat (20) @(negedge mclk);
      check({status, overrange, gate_open, window_accept, out_value}, 0);
      rst_n <= 1'b1;
      conv(-1, -1, 2, -1, -1, 20);
      check(tp, 0);
      check(gw, 0);
      // second start while latched must not disturb the conversion
      conv(0, 34, 30, -1, -1, 300);
      v1 = val;
      check(gw, 20);
      check(ts, 1);
      check(tp, 1);
      check(fg - sc >= 10 && fg - sc <= 13, 1);
      check(status.busy, 0);
      conv(0, -1, 60, -1, -1, 300);
      check(val - v1, 30);
      // start right after the gate closes falls in the dead time
      conv(0, -1, 30, -1, -1, 75);
      conv(0, -1, 30, -1, -1, 300);
      check(ts, 0);
      check(gw, 0);
      conv(0, -1, -1, -1, -1, 400);
      check(ovr, 1);
      check(gw, 0);
      cfg.stb_src = ics_pkg::ICS_STB_START;
      // stop late enough that the start delay lands inside the short timeout
      conv(0, -1, 70, -1, -1, 400);
      check(fg >= 100 && fg <= 106, 1);
      check(gw, 20);
      cfg.stb_src = ics_pkg::ICS_STB_EXT;
      early = 1'b1;
      conv(0, -1, 30, 10, -1, 100);
      early = 1'b0;
      check(gw, 0);
      check(tse, 0);
      conv(-1, -1, -1, -1, -1, 100);
      conv(0, -1, 30, 60, -1, 400);
      check(fg >= 61 && fg <= 65, 1);
      check(gw, 20);
      // long timeout keeps the start latched past the short limit
      cfg.tmo_long = 1'b1;
      conv(0, -1, 30, -1, -1, 100);
      check(tse, 1);
      conv(-1, -1, -1, -1, -1, 1000);
      check(tse, 1);
      conv(-1, -1, -1, -1, -1, 300);
      check(tse, 0);
      cfg.tmo_long = 1'b0;
      cfg.stb_src = ics_pkg::ICS_STB_STOP;
      h = v1 >> 1;
      for (int k = 0; k < 7; k++) begin
         cfg.lower_level_threshold = h - 16'(lo_off[k]);
         cfg.upper_level_threshold = wm[k] ? 16'(up_off[k]) : h + 16'(up_off[k]);
         cfg.window_mode = wm[k];
         cfg.accept_gating = ag[k];
         conv(0, -1, 30, -1, -1, 200);
         check(win, ew[k]);
         check(gw, (ag[k] && !ew[k]) ? 0 : 20);
      end
      cfg.accept_gating = 1'b0;
      conv(0, 20, -1, -1, 10, 300);
      check(tsl, 0);
      check(gw, 0);
      // synchronous reset between stop and gate drops the conversion
      conv(0, -1, 30, -1, -1, 35);
      check(status.true_stop, 1);
      @(negedge mclk);
      sync_reset <= 1'b1;
      @(negedge mclk);
      sync_reset <= 1'b0;
      conv(-1, -1, -1, -1, -1, 100);
      check(gw, 0);
      check(tse, 0);
      for (int k = 0; k < 3; k++) begin
         cfg.coinc_mode = k < 2;
         gate_in = k > 0;
         conv(0, -1, 30, -1, -1, 200);
         check(ts, k == 1);
      end
      wrap_up();
   end
endmodule
